// >>> design/rpm_reset_power_ctrl.sv
// reset sequencer, reset source recording and idle/stop power modes
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module rpm_reset_power_ctrl #(
  parameter int POR_CYCLES = rpm_pkg::POR_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // reset sources
  input  wire logic        reset_pin_i,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_o,
  input  wire logic        supply_ok_i,
  input  wire logic        supply_monitor_enable_pin_i,
  input  wire logic        convert_start_input_i,
  input  wire logic        comparator0_below_i,
  input  wire logic        clock_loss_timeout_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        osc_stable_i,
  // processor handshake
  input  wire logic        instr_end_i,
  input  wire logic        irq_pending_i,
  // reset and clock controls
  output logic             sys_rst_n_o,
  output logic             port_latch_preset_o,
  output logic             weak_pullup_en_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             osc_en_o,
  // uart controls
  output logic             uart0_baud_div2_en_o,
  output logic             uart1_baud_div2_en_o,
  output logic             uart0_status_view_sel_o,
  output logic             uart1_status_view_sel_o
);

  rpm_pkg::rpm_regs_s q;
  rpm_pkg::rpm_regs_s next_q;

  localparam logic [rpm_pkg::CNT_W-1:0] POR_LAST  = rpm_pkg::CNT_W'(POR_CYCLES - 1);
  localparam logic [rpm_pkg::CNT_W-1:0] EXIT_LAST = rpm_pkg::CNT_W'(rpm_pkg::EXIT_CYCLES - 1);

  // register read view; stop/idle and reserved bits read as zero
  function automatic logic [7:0] rd_view(input logic [7:0] idx, input rpm_pkg::rpm_regs_s r);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      rpm_pkg::IDX_POWER_CONTROL: begin
        v[rpm_pkg::PC_UART0_DOUBLER] = r.u0_dbl;
        v[rpm_pkg::PC_UART0_STATSEL] = r.u0_sel;
        v[rpm_pkg::PC_UART1_DOUBLER] = r.u1_dbl;
        v[rpm_pkg::PC_UART1_STATSEL] = r.u1_sel;
      end
      rpm_pkg::IDX_RESET_SOURCE: begin
        v[rpm_pkg::NUM_SRC-1:0] = r.flags;
      end
      rpm_pkg::IDX_OSC_CONTROL: begin
        v[rpm_pkg::OC_CLK_LOSS_EN] = r.mcd_en;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_view

  // command bit written to the reset source register; shared by the soft and forced power-on paths
  function automatic logic rs_cmd(input logic w, input logic [7:0] i, input logic [31:0] d, input int b);
    return w && (i == rpm_pkg::IDX_RESET_SOURCE) && d[b];
  endfunction : rs_cmd

  // one step of a saturating sequence counter, shared by the power-on and exit timeouts
  function automatic logic [rpm_pkg::CNT_W-1:0] count_up(input logic [rpm_pkg::CNT_W-1:0] c,
                                                         input logic [rpm_pkg::CNT_W-1:0] last);
    logic [rpm_pkg::CNT_W-1:0] n;
    n = c;
    if (c < last) begin
      n = c + 1'b1;
    end
    return n;
  endfunction : count_up

  logic [7:0]                 idx;
  logic                       wr;
  logic                       sup_low;
  logic [rpm_pkg::NUM_SRC-1:0] src;
  logic                       osc_ok;
  logic                       level_active;

  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    idx = avs_address_i[9:2];
    // each lane placed by its position constant so the map cannot drift
    next_q.sy1[rpm_pkg::SY_PIN] = reset_pin_i;
    next_q.sy1[rpm_pkg::SY_SUP] = supply_ok_i;
    next_q.sy1[rpm_pkg::SY_MON] = supply_monitor_enable_pin_i;
    next_q.sy1[rpm_pkg::SY_CNV] = convert_start_input_i;
    next_q.sy1[rpm_pkg::SY_CMP] = comparator0_below_i;
    next_q.sy1[rpm_pkg::SY_MCD] = clock_loss_timeout_i;
    next_q.sy1[rpm_pkg::SY_OSC] = osc_stable_i;
    next_q.sy2 = q.sy1;
    osc_ok = q.sy2[rpm_pkg::SY_OSC];

    // one wait cycle: capture on the first cycle, complete on the second
    if ((avs_read_i || avs_write_i) && !q.ack) begin
      next_q.ack   = 1'b1;
      next_q.rdata = rd_view(idx, q);
    end
    // writes only land while the processor runs; in reset registers other than cnv_en and cmp_en stay at defaults
    wr = avs_write_i && q.ack && avs_byteenable_i[0] && (q.st == rpm_pkg::ST_RUN);

    sup_low = q.sy2[rpm_pkg::SY_MON] && !q.sy2[rpm_pkg::SY_SUP];
    src = '0;
    src[rpm_pkg::RS_PIN] = !q.sy2[rpm_pkg::SY_PIN] && (q.st != rpm_pkg::ST_POR);
    src[rpm_pkg::RS_POR] = sup_low || rs_cmd(wr, idx, avs_writedata_i, rpm_pkg::RS_POR);
    src[rpm_pkg::RS_MCD] = q.mcd_en && q.sy2[rpm_pkg::SY_MCD];
    src[rpm_pkg::RS_WDT] = watchdog_timeout_i;
    src[rpm_pkg::RS_SW]  = rs_cmd(wr, idx, avs_writedata_i, rpm_pkg::RS_SW);
    src[rpm_pkg::RS_CMP] = q.cmp_en && q.sy2[rpm_pkg::SY_CMP];
    src[rpm_pkg::RS_CNV] = q.cnv_en && !q.sy2[rpm_pkg::SY_CNV];
    // level sources keep the device in hold while asserted, except clock loss, whose mcd_en clears in the first hold cycle
    level_active = src[rpm_pkg::RS_PIN] || src[rpm_pkg::RS_CMP] || src[rpm_pkg::RS_CNV] ||
                   src[rpm_pkg::RS_MCD];

    // register writes
    if (wr) begin
      unique case (idx)
        rpm_pkg::IDX_POWER_CONTROL: begin
          // reserved bits 5 and 2 are not stored
          next_q.u0_dbl = avs_writedata_i[rpm_pkg::PC_UART0_DOUBLER];
          next_q.u0_sel = avs_writedata_i[rpm_pkg::PC_UART0_STATSEL];
          next_q.u1_dbl = avs_writedata_i[rpm_pkg::PC_UART1_DOUBLER];
          next_q.u1_sel = avs_writedata_i[rpm_pkg::PC_UART1_STATSEL];
          if (avs_writedata_i[rpm_pkg::PC_STOP]) begin
            next_q.stop_req = 1'b1;
          end
          if (avs_writedata_i[rpm_pkg::PC_IDLE]) begin
            next_q.idle_req = 1'b1;
          end
        end
        rpm_pkg::IDX_RESET_SOURCE: begin
          next_q.cnv_en = avs_writedata_i[rpm_pkg::RS_CNV];
          next_q.cmp_en = avs_writedata_i[rpm_pkg::RS_CMP];
        end
        rpm_pkg::IDX_OSC_CONTROL: begin
          next_q.mcd_en = avs_writedata_i[rpm_pkg::OC_CLK_LOSS_EN];
        end
        default: next_q.mcd_en = q.mcd_en;
      endcase
    end

    // power modes take effect once the writing instruction has ended
    if (q.stop_req && instr_end_i) begin
      next_q.stop_mode = 1'b1;
      next_q.stop_req  = 1'b0;
    end
    if (q.idle_req && instr_end_i) begin
      next_q.idle_mode = 1'b1;
      next_q.idle_req  = 1'b0;
    end
    if (q.idle_mode && irq_pending_i) begin
      next_q.idle_mode = 1'b0;
    end

    // reset sequencer
    unique case (q.st)
      rpm_pkg::ST_RUN: begin
        if (src[rpm_pkg::RS_POR]) begin
          next_q.st    = rpm_pkg::ST_POR;
          next_q.cnt   = '0;
          next_q.cause = '0;
          next_q.cause[rpm_pkg::RS_POR] = 1'b1;
        end else if (|src) begin
          next_q.st    = rpm_pkg::ST_HOLD;
          next_q.cause = src;
        end
      end
      rpm_pkg::ST_HOLD: begin
        next_q.cause = q.cause | src;
        if (src[rpm_pkg::RS_POR]) begin
          next_q.st    = rpm_pkg::ST_POR;
          next_q.cnt   = '0;
          next_q.cause = '0;
          next_q.cause[rpm_pkg::RS_POR] = 1'b1;
        end else if (!level_active) begin
          next_q.st  = rpm_pkg::ST_EXIT;
          next_q.cnt = '0;
        end
      end
      rpm_pkg::ST_EXIT: begin
        if (src[rpm_pkg::RS_POR]) begin
          next_q.st    = rpm_pkg::ST_POR;
          next_q.cnt   = '0;
          next_q.cause = '0;
          next_q.cause[rpm_pkg::RS_POR] = 1'b1;
        end else if (level_active) begin
          next_q.st    = rpm_pkg::ST_HOLD;
          next_q.cause = q.cause | src;
        end else if (q.cnt >= EXIT_LAST && osc_ok) begin
          next_q.st    = rpm_pkg::ST_RUN;
          next_q.flags = q.cause;
        end else begin
          next_q.cnt = count_up(q.cnt, EXIT_LAST);
        end
      end
      rpm_pkg::ST_POR: begin
        if (sup_low) begin
          next_q.cnt = '0;
        end else if (q.cnt >= POR_LAST && osc_ok && q.sy2[rpm_pkg::SY_PIN]) begin
          // the pin is let go at the timeout; waiting until it reads high keeps the block's
          // own drive from coming back through the synchroniser as an outside pin reset
          next_q.st    = rpm_pkg::ST_RUN;
          next_q.flags = '0;
          next_q.flags[rpm_pkg::RS_POR] = 1'b1;
        end else begin
          next_q.cnt = count_up(q.cnt, POR_LAST);
        end
      end
    endcase

    // every control register except the cnv_en and cmp_en enables returns to its default while in reset
    if (q.st != rpm_pkg::ST_RUN) begin
      next_q.u0_dbl    = rpm_pkg::PC_RESET[rpm_pkg::PC_UART0_DOUBLER];
      next_q.u0_sel    = rpm_pkg::PC_RESET[rpm_pkg::PC_UART0_STATSEL];
      next_q.u1_dbl    = rpm_pkg::PC_RESET[rpm_pkg::PC_UART1_DOUBLER];
      next_q.u1_sel    = rpm_pkg::PC_RESET[rpm_pkg::PC_UART1_STATSEL];
      next_q.stop_req  = 1'b0;
      next_q.idle_req  = 1'b0;
      next_q.stop_mode = 1'b0;
      next_q.idle_mode = 1'b0;
      next_q.mcd_en    = 1'b0;
    end
    // enables stay armed through hold so a level source keeps its reset;
    // they drop on the way out
    if (q.st != rpm_pkg::ST_RUN && next_q.st == rpm_pkg::ST_RUN) begin
      next_q.cnv_en = 1'b0;
      next_q.cmp_en = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q       <= '0;
      q.st    <= rpm_pkg::ST_POR;
      q.cause <= 7'h02;
    end else begin
      q <= next_q;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.ack;
  assign avs_readdata_o    = {24'h000000, q.rdata};

  // deasserts only on a clock edge since it comes straight from the state flop
  // no memory clear here: data memory is never touched by this block
  assign sys_rst_n_o         = (q.st == rpm_pkg::ST_RUN);
  assign port_latch_preset_o = (q.st != rpm_pkg::ST_RUN);
  assign weak_pullup_en_o    = (q.st == rpm_pkg::ST_RUN);
  // only the power-on path drives the pin; other sources leave it alone
  assign reset_pin_o         = 1'b0;
  assign reset_pin_oe_o      = (q.st == rpm_pkg::ST_POR) && (q.cnt < POR_LAST);
  assign cpu_clk_en_o        = (q.st == rpm_pkg::ST_RUN) && !q.stop_mode && !q.idle_mode;
  assign periph_clk_en_o     = !q.stop_mode;
  assign osc_en_o            = !q.stop_mode;

  assign uart0_baud_div2_en_o    = !q.u0_dbl;
  assign uart1_baud_div2_en_o    = !q.u1_dbl;
  assign uart0_status_view_sel_o = q.u0_sel;
  assign uart1_status_view_sel_o = q.u1_sel;

endmodule : rpm_reset_power_ctrl

// >>> design/rpm_pkg.sv
// constants and types for the reset and power mode controller
package rpm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_RESET_SOURCE  = 8'hef;
  localparam logic [7:0] IDX_OSC_CONTROL   = 8'hb2;

  // power_control_reg fields
  localparam int PC_UART0_DOUBLER = 7;
  localparam int PC_UART0_STATSEL = 6;
  localparam int PC_UART1_DOUBLER = 4;
  localparam int PC_UART1_STATSEL = 3;
  localparam int PC_STOP          = 1;
  localparam int PC_IDLE          = 0;
  localparam logic [7:0] PC_RESET = 8'h00;

  // reset_source_reg fields, also the cause vector positions
  localparam int RS_PIN  = 0;
  localparam int RS_POR  = 1;
  localparam int RS_MCD  = 2;
  localparam int RS_WDT  = 3;
  localparam int RS_SW   = 4;
  localparam int RS_CMP  = 5;
  localparam int RS_CNV  = 6;
  localparam int NUM_SRC = 7;

  // internal_osc_control_reg field
  localparam int OC_CLK_LOSS_EN = 7;

  // timing
  localparam int CLK_MHZ        = 100;
  localparam int POR_TIMEOUT_MS = 100;
  localparam int POR_CYCLES     = POR_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int EXIT_CYCLES    = 12;
  localparam int CNT_W          = 24;

  // synchroniser lane positions
  localparam int SY_PIN   = 0;
  localparam int SY_SUP   = 1;
  localparam int SY_MON   = 2;
  localparam int SY_CNV   = 3;
  localparam int SY_CMP   = 4;
  localparam int SY_MCD   = 5;
  localparam int SY_OSC   = 6;
  localparam int SY_W     = 7;

  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_HOLD = 2'b01,
    ST_EXIT = 2'b10,
    ST_RUN  = 2'b11
  } rpm_state_e;

  typedef struct packed {
    logic [SY_W-1:0]    sy1;
    logic [SY_W-1:0]    sy2;
    rpm_state_e         st;
    logic [CNT_W-1:0]   cnt;
    logic [NUM_SRC-1:0] cause;
    logic [NUM_SRC-1:0] flags;
    logic               u0_dbl;
    logic               u0_sel;
    logic               u1_dbl;
    logic               u1_sel;
    logic               cnv_en;
    logic               cmp_en;
    logic               mcd_en;
    logic               stop_req;
    logic               idle_req;
    logic               stop_mode;
    logic               idle_mode;
    logic               ack;
    logic [7:0]         rdata;
  } rpm_regs_s;
endpackage : rpm_pkg

// >>> verification/rpm_reset_power_ctrl_sva.sv
// concurrent checks on the reset and power mode controller ports
`timescale 1ns/10ps
module rpm_reset_power_ctrl_sva (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        reset_pin_i,
  input wire logic        reset_pin_oe_o,
  input wire logic        supply_ok_i,
  input wire logic        supply_monitor_enable_pin_i,
  input wire logic        instr_end_i,
  input wire logic        sys_rst_n_o,
  input wire logic        port_latch_preset_o,
  input wire logic        weak_pullup_en_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        periph_clk_en_o,
  input wire logic        osc_en_o
);
  logic [3:0] pin_hi;
  logic       wr_done;

  // pin low while the device itself drives it does not restart the count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pin_hi <= 4'h0;
    else if (!reset_pin_i && !reset_pin_oe_o) pin_hi <= 4'h0;
    else if (pin_hi != 4'hf) pin_hi <= pin_hi + 4'h1;
  end
  assign wr_done = avs_write_i && !avs_waitrequest_o && sys_rst_n_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  stop_after_instr_a: assert property ($fell(osc_en_o) |-> $past(instr_end_i))
    else $error("stop entered without instruction end");
  stop_clocks_a: assert property (!osc_en_o |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clock still running in stop");
  stop_exit_a: assert property ($rose(osc_en_o) |-> !sys_rst_n_o || !$past(sys_rst_n_o))
    else $error("stop left without reset");
  mode_bits_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h21c
    |-> avs_readdata_o[1:0] == 2'b00)
    else $error("mode select bits read nonzero");
  rst_halt_a: assert property (!sys_rst_n_o |-> !cpu_clk_en_o)
    else $error("cpu clock on in reset");
  rst_pins_a: assert property (weak_pullup_en_o == sys_rst_n_o && port_latch_preset_o != sys_rst_n_o)
    else $error("pull-up or latch preset wrong");
  supply_drive_a: assert property (!supply_ok_i && supply_monitor_enable_pin_i
    |-> ##[1:4] (reset_pin_oe_o && !sys_rst_n_o))
    else $error("supply loss did not drive pin");
  pin_release_a: assert property ($rose(sys_rst_n_o) |-> pin_hi >= 4'hc)
    else $error("released too soon after pin");
  soft_reset_a: assert property (wr_done && avs_address_i == 10'h3bc && avs_writedata_i[4]
    |-> ##[1:3] !sys_rst_n_o)
    else $error("software reset not taken");
endmodule : rpm_reset_power_ctrl_sva

bind rpm_reset_power_ctrl rpm_reset_power_ctrl_sva u_rpm_reset_power_ctrl_sva (.clk_i, .arst_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .reset_pin_i, .reset_pin_oe_o, .supply_ok_i, .supply_monitor_enable_pin_i, .instr_end_i,
  .sys_rst_n_o, .port_latch_preset_o, .weak_pullup_en_o, .cpu_clk_en_o, .periph_clk_en_o, .osc_en_o);

// >>> verification/rpm_board_model.sv
// board side of the reset pin: pull-up, reset switch and monitor strap
`timescale 1ns/10ps
module rpm_board_model (
  input  wire logic press_i,
  input  wire logic dut_oe_i,
  input  wire logic dut_drv_i,
  output logic      pin_o,
  output logic      mon_en_o
);
  // pull-up wins whenever nobody pulls the pin low
  assign pin_o    = !((dut_oe_i && !dut_drv_i) || press_i);
  assign mon_en_o = 1'b1;
endmodule : rpm_board_model

// >>> verification/rpm_reset_power_ctrl_bench.sv
// self-checking bench for the reset and power mode controller
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module rpm_reset_power_ctrl_bench;
  localparam logic [9:0] PC = {rpm_pkg::IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] RS = {rpm_pkg::IDX_RESET_SOURCE, 2'b00};
  localparam logic [9:0] OC = {rpm_pkg::IDX_OSC_CONTROL, 2'b00};
  logic        clk_i = 1'b0, arst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [9:0]  avs_address_i = 10'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        press = 1'b0, supply_ok_i = 1'b1, convert_start_input_i = 1'b1, osc_stable_i = 1'b1;
  logic        comparator0_below_i = 1'b0, clock_loss_timeout_i = 1'b0, watchdog_timeout_i = 1'b0;
  logic        instr_end_i = 1'b0, irq_pending_i = 1'b0, supply_monitor_enable_pin_i, reset_pin_i;
  logic        avs_waitrequest_o, reset_pin_o, reset_pin_oe_o, sys_rst_n_o, port_latch_preset_o;
  logic        weak_pullup_en_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o, uart0_baud_div2_en_o;
  logic        uart1_baud_div2_en_o, uart0_status_view_sel_o, uart1_status_view_sel_o;
  logic [7:0]  exp_q[$], v, exp_v;
  logic [7:0]  fl[8] = '{8'h01, 8'h10, 8'h08, 8'h04, 8'h20, 8'h40, 8'h02, 8'h02};
  logic [31:0] seed = 32'h42975872;
  int          failures = 0, total_checks = 0, cyc = 0, n;

  rpm_reset_power_ctrl #(.POR_CYCLES(50)) u_rpm_reset_power_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .supply_ok_i(supply_ok_i),
    .supply_monitor_enable_pin_i(supply_monitor_enable_pin_i), .convert_start_input_i(convert_start_input_i),
    .comparator0_below_i(comparator0_below_i), .clock_loss_timeout_i(clock_loss_timeout_i),
    .watchdog_timeout_i(watchdog_timeout_i), .osc_stable_i(osc_stable_i), .instr_end_i(instr_end_i),
    .irq_pending_i(irq_pending_i), .sys_rst_n_o(sys_rst_n_o), .port_latch_preset_o(port_latch_preset_o),
    .weak_pullup_en_o(weak_pullup_en_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .osc_en_o(osc_en_o), .uart0_baud_div2_en_o(uart0_baud_div2_en_o),
    .uart1_baud_div2_en_o(uart1_baud_div2_en_o), .uart0_status_view_sel_o(uart0_status_view_sel_o),
    .uart1_status_view_sel_o(uart1_status_view_sel_o));
  rpm_board_model u_rpm_board_model (.press_i(press), .dut_oe_i(reset_pin_oe_o), .dut_drv_i(reset_pin_o),
    .pin_o(reset_pin_i), .mon_en_o(supply_monitor_enable_pin_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // a hang is cut short here and counted
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  // read results are compared in order of request
  always @(posedge clk_i) begin
    if (avs_read_i && !avs_waitrequest_o) begin
      exp_v = exp_q.pop_front();
      `CHK(avs_readdata_o[7:0], exp_v)
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    avs_writedata_i <= {24'h0, d};
    @(posedge clk_i iff !avs_waitrequest_o);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wt(input logic s);
    n = 0;
    while (sys_rst_n_o !== s) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wt

  task automatic fin();
    @(posedge clk_i) instr_end_i <= 1'b1;
    @(posedge clk_i) instr_end_i <= 1'b0;
    @(negedge clk_i);
  endtask : fin

  task automatic src(input int k, input logic [7:0] e);
    if (k == 3) begin
      wr(OC, 8'h80);
      wr(PC, 8'h02);
      @(negedge clk_i);
      `CHK(osc_en_o, 1'b1)
      fin();
      `CHK({cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 3'b000)
    end
    if (k == 4) wr(RS, 8'h20);
    if (k == 5) wr(RS, 8'h40);
    if (k == 1) wr(RS, 8'h10);
    else if (k == 6) wr(RS, 8'h02);
    else @(posedge clk_i) case (k)
      0: press <= 1'b1;
      2: watchdog_timeout_i <= 1'b1;
      3: clock_loss_timeout_i <= 1'b1;
      4: comparator0_below_i <= 1'b1;
      5: convert_start_input_i <= 1'b0;
      default: supply_ok_i <= 1'b0;
    endcase
    wt(1'b0);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({reset_pin_o, reset_pin_oe_o}, {1'b0, k >= 6})
    @(posedge clk_i);
    {press, watchdog_timeout_i, clock_loss_timeout_i, comparator0_below_i} <= 4'h0;
    {convert_start_input_i, supply_ok_i} <= 2'b11;
    // an unsteady clock must keep the watchdog reset from ending
    osc_stable_i <= (k != 2);
    if (k == 2) begin
      repeat (30) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(sys_rst_n_o, 1'b0)
      @(posedge clk_i) osc_stable_i <= 1'b1;
    end
    wt(1'b1);
    if (k == 0) `CHK(n >= 12, 1'b1)
    @(negedge clk_i);
    `CHK({cpu_clk_en_o, osc_en_o, weak_pullup_en_o}, 3'b111)
    rd(RS, e);
  endtask : src

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({sys_rst_n_o, reset_pin_oe_o, port_latch_preset_o, weak_pullup_en_o}, 4'b0110)
    @(posedge clk_i) arst_n_i <= 1'b1;
    wt(1'b1);
    rd(RS, 8'h02);
    rd(PC, 8'h00);
    rd(10'h3fc, 8'h00);
    @(posedge clk_i) comparator0_below_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(sys_rst_n_o, 1'b1)
    @(posedge clk_i) comparator0_below_i <= 1'b0;
    repeat (4) begin
      v = 8'(rnd()) & 8'hd8;
      wr(PC, v);
      rd(PC, v);
      @(negedge clk_i);
      `CHK({uart0_baud_div2_en_o, uart0_status_view_sel_o, uart1_baud_div2_en_o, uart1_status_view_sel_o},
        {~v[7], v[6], ~v[4], v[3]})
    end
    wr(PC, 8'h01);
    fin();
    `CHK({cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 3'b011)
    rd(PC, 8'h00);
    @(posedge clk_i) irq_pending_i <= 1'b1;
    @(posedge clk_i) irq_pending_i <= 1'b0;
    @(negedge clk_i);
    `CHK(cpu_clk_en_o, 1'b1)
    wr(PC, 8'hd8);
    for (int k = 0; k < 8; k++) src(k, fl[k]);
    rd(PC, 8'h00);
    repeat (4) @(posedge clk_i);
    stop_test();
  end
endmodule : rpm_reset_power_ctrl_bench
